/* src/ata_irq_pkg.sv */
// Purpose: shared constants of the drive-interface interrupt/status block
// Assumes: byte-wide MCU external data space, 16-bit addresses
// Notes:   offsets are byte addresses in the MCU data space
`default_nettype none
package ata_irq_pkg;
  // register byte addresses
  localparam logic [15:0] ADDR_SRC2    = 16'hF0E8;
  localparam logic [15:0] ADDR_EN2     = 16'hF0E9;
  localparam logic [15:0] ADDR_STATUS  = 16'hF0EA;
  // second source register field positions
  localparam int          SRC2_NDA     = 0;  // nondata_cmd_mismatch
  localparam int          SRC2_DSEQ    = 1;  // packet_data_sequence_error
  localparam int          SRC2_SEQ     = 2;  // packet_sequence_error
  localparam int          SRC2_BSY     = 3;  // drive_busy_at_start
  localparam logic [7:0]  SRC2_IMPL    = 8'h0F;  // bits 7..4 reserved
  // status register field positions
  localparam int          STAT_OVRUN   = 0;
  localparam int          STAT_DMARQ   = 1;
  localparam int          STAT_DMACK   = 2;
  localparam int          STAT_INTRQ   = 3;
  // reset values
  localparam logic [7:0]  SRC2_RESET   = 8'h00;
  localparam logic [7:0]  EN2_RESET    = 8'h00;
  localparam logic        OVRUN_RESET  = 1'b0;
  // interrupt vector and packet command code
  localparam logic [7:0]  ATA_VECTOR   = 8'h48;
  localparam logic [7:0]  NO_VECTOR    = 8'h00;
  localparam logic [7:0]  PKT_CMD_CODE = 8'hA0;
  // first source register: drive interrupt and pending positions
  localparam int          SRC1_DRV_INT = 0;
  localparam int          SRC1_PEND    = 1;
  // pin synchroniser depth
  localparam int          SYNC_STAGES  = 2;
endpackage
`default_nettype wire

/* src/pin_sync.sv */
// Purpose: two-flop synchroniser for asynchronous drive pins
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`default_nettype none
module pin_sync
  import ata_irq_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  // refuse a width the flops cannot serve, and any depth but two
  if (WIDTH < 1 || SYNC_STAGES != 2) begin : g_bad_cfg
    $error("pin_sync: WIDTH below 1 or depth not two");
  end

  logic [WIDTH-1:0] meta_q;  // first stage, read only by second stage

  // both stages reset to low, pins idle low except active-low dmack_n, which idles high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* src/ata_bridge_irq_status.sv */
// Purpose: second interrupt source/enable registers and interface status
// Assumes: transfer engine events are one-cycle pulses on clk
// Notes:   read data appears one cycle after the read strobe
//          drive pins reach the status register two flops late
//
// Functional notes
// - first sources except drive interrupt and pending bits join vector 0x48
// - pending flag when any second source active
// - mask bit one enables its source
// - bit0: nondata command but drive wants data
// - bit1: packet mode data phase sequence error
// - bit2: sequence error between A0h and packet
// - bit3: drive busy at start, suppress command
// - status bits 3..1 mirror pins, read-only
// - overrun flag when drive exceeds host length
// - overrun also raises byte count mismatch
// - auto PIO: interrupt with DRQ sets overrun
// - UDMA overrun: pause, flag on DMARQ not INTRQ
// - overrun cleared by write one or start
// - source bits clear only on write one
`default_nettype none
module ata_bridge_irq_status
  import ata_irq_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // mcu external data space access
  input  wire logic [15:0] mcu_addr,
  input  wire logic        mcu_wr,
  input  wire logic        mcu_rd,
  input  wire logic [7:0]  mcu_wdata,
  output var  logic [7:0]  mcu_rdata,
  // first interrupt register set, held elsewhere
  input  wire logic [7:0]  irq_source_first_reg,
  input  wire logic [7:0]  irq_enable_first_reg,
  output var  logic        second_reg_pending_flag,
  // interrupt to the mcu
  output var  logic        ata_irq,
  output var  logic [7:0]  ata_irq_vector,
  // transfer engine events and modes
  input  wire logic        transfer_start_bit,
  input  wire logic        drive_busy,
  input  wire logic        cmd_issue,
  input  wire logic        nondata_cmd_cfg,
  input  wire logic        drive_drq,
  input  wire logic        packet_mode,
  input  wire logic        full_auto_seq,
  input  wire logic        cmd_code_wr,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        packet_bytes_sent,
  input  wire logic        seq_err,
  input  wire logic        data_phase,
  input  wire logic        host_overrun,
  input  wire logic        pio_auto,
  input  wire logic        status_read_done,
  input  wire logic        udma_overrun,
  // outputs to transfer engine
  output var  logic        auto_cmd_go,
  output var  logic        byte_count_mismatch_irq,
  output var  logic        udma_pause,
  // drive pins, asynchronous
  input  wire logic        pin_dmarq,
  input  wire logic        pin_dmack_n,
  input  wire logic        pin_intrq
);
  // udma overrun arbitration states
  typedef enum logic [1:0] {OV_IDLE, OV_DROP, OV_WATCH} ov_state_t;

  logic [7:0] src2_q, src2_d;       // second interrupt sources
  logic [7:0] en2_q;                // second interrupt enables
  logic       ovrun_q, ovrun_d;     // device_overrun_flag
  logic       seq_win_q, seq_win_d; // between A0h and packet bytes
  ov_state_t  ov_q, ov_d;
  logic [2:0] pins_s;               // {intrq, dmack_n, dmarq} synced
  logic       dmarq_s, dmack_n_s, intrq_s;  // synced pin levels

  // pins are asynchronous to clk, so they pass two flops first
  // limitation: the status mirror lags the pins by two to three cycles
  pin_sync #(.WIDTH(3)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({pin_intrq, pin_dmack_n, pin_dmarq}),
    .sync_out (pins_s)
  );
  assign dmarq_s = pins_s[0];
  assign dmack_n_s = pins_s[1];
  assign intrq_s = pins_s[2];

  // address decode, used for both read and write
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    return a == r;
  endfunction
  wire wr_src2 = mcu_wr && hit(mcu_addr, ADDR_SRC2);
  wire wr_en2  = mcu_wr && hit(mcu_addr, ADDR_EN2);
  wire wr_stat = mcu_wr && hit(mcu_addr, ADDR_STATUS);

  // event detection for the second source register
  // every event is a one-cycle pulse from the engine, so no source
  // bit needs an edge detector of its own
  wire ev_nda  = cmd_issue && nondata_cmd_cfg && drive_drq;
  wire ev_dseq = packet_mode && seq_err && data_phase;
  wire ev_seq  = packet_mode && full_auto_seq && seq_err
                 && seq_win_q && !data_phase;
  wire ev_bsy  = transfer_start_bit && drive_busy;
  // busy drive must not get the automatic command
  wire go_d    = transfer_start_bit && !drive_busy;
  wire [7:0] ev2 = {4'h0, ev_bsy, ev_seq, ev_dseq, ev_nda};
  wire [7:0] clr2 = wr_src2 ? mcu_wdata : 8'h00;

  // a new event beats a same-cycle write-one clear
  // the clear mask only exists in the cycle of the write itself
  assign src2_d = ((src2_q & ~clr2) | ev2) & SRC2_IMPL;

  // packet window opens on A0h, closes once packet bytes go out
  wire a0_wr = cmd_code_wr && (cmd_code == PKT_CMD_CODE);
  assign seq_win_d = (a0_wr && packet_mode && full_auto_seq) ? 1'b1 :
                     packet_bytes_sent ? 1'b0 : seq_win_q;
  // limitation: a second A0h write while open just keeps it open

  // udma overrun: wait for dmarq to drop, then see who returns first
  // the drive either ends with an interrupt or asks for more data, and
  // only the second means it really holds more than the host wants
  always_comb begin
    ov_d = ov_q;
    unique case (ov_q)
      OV_IDLE:  if (udma_overrun) ov_d = OV_DROP;
      OV_DROP:  if (intrq_s) ov_d = OV_IDLE;
                else if (!dmarq_s) ov_d = OV_WATCH;
      OV_WATCH: if (intrq_s || dmarq_s) ov_d = OV_IDLE;
      default:  ov_d = OV_IDLE;  // unused code falls back to idle
    endcase
  end
  // intrq wins over dmarq when both show in the same cycle
  wire ev_udma = (ov_q == OV_WATCH) && dmarq_s && !intrq_s;

  // overrun sources; set wins over both kinds of clear
  // a pio overrun needs a finished status read that still shows drq
  wire ev_pio = pio_auto && status_read_done && drive_drq;
  wire ev_ov  = host_overrun || ev_pio || ev_udma;
  wire ov_clr = (wr_stat && mcu_wdata[STAT_OVRUN])
                || transfer_start_bit;
  assign ovrun_d = ev_ov ? 1'b1 : (ov_clr ? 1'b0 : ovrun_q);

  // interrupt combination; drive interrupt bit stays out of the vector
  // pending flag and irq both use masked sources, so a disabled
  // second source never reaches the mcu
  wire [7:0] act1  = irq_source_first_reg & irq_enable_first_reg;
  wire [7:0] act2  = src2_q & en2_q;
  wire       pend  = |act2;
  wire [7:0] keep1 = ~(8'h01 << SRC1_DRV_INT) & ~(8'h01 << SRC1_PEND);
  wire       irq_d = |(act1 & keep1) || pend;

  // read mux; reserved bits of status read zero
  // unmapped addresses read zero rather than stale data
  wire [7:0] stat_rd = {4'h0, intrq_s, dmack_n_s, dmarq_s,
                        ovrun_q};
  wire [7:0] rd_mux  = hit(mcu_addr, ADDR_SRC2)   ? src2_q  :
                       hit(mcu_addr, ADDR_EN2)    ? en2_q   :
                       hit(mcu_addr, ADDR_STATUS) ? stat_rd : 8'h00;

  // register state
  // the mask has no hardware setter, only the mcu write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src2_q    <= SRC2_RESET;
      en2_q     <= EN2_RESET;
      ovrun_q   <= OVRUN_RESET;
      seq_win_q <= 1'b0;
      ov_q      <= OV_IDLE;
    end else begin
      src2_q    <= src2_d;
      ovrun_q   <= ovrun_d;
      seq_win_q <= seq_win_d;
      ov_q      <= ov_d;
      if (wr_en2) en2_q <= mcu_wdata;
    end
  end

  // registered outputs
  // everything the mcu or engine sees leaves a flop, one cycle late
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mcu_rdata               <= 8'h00;
      second_reg_pending_flag <= 1'b0;
      ata_irq                 <= 1'b0;
      ata_irq_vector          <= NO_VECTOR;
      auto_cmd_go             <= 1'b0;
      byte_count_mismatch_irq <= 1'b0;
      udma_pause              <= 1'b0;
    end else begin
      if (mcu_rd) mcu_rdata <= rd_mux;
      second_reg_pending_flag <= pend;
      ata_irq                 <= irq_d;
      ata_irq_vector          <= irq_d ? ATA_VECTOR : NO_VECTOR;
      auto_cmd_go             <= go_d;
      byte_count_mismatch_irq <= ev_ov;
      udma_pause              <= (ov_d != OV_IDLE);
    end
  end

  // checks on the logic above
  // checks are off in reset, so the first edge after release compares
  // against reset values, never against unknowns
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_busy_blocks_go: assert property (
    transfer_start_bit && drive_busy |=> !auto_cmd_go && src2_q[SRC2_BSY])
    else $error("busy start did not block command");
  chk_nda_sets: assert property (
    ev_nda |=> src2_q[SRC2_NDA])
    else $error("nondata mismatch not recorded");
  chk_w1c_keeps: assert property (
    wr_src2 && mcu_wdata == 8'h00 && ev2 == 8'h00 |=> $stable(src2_q))
    else $error("write zero changed source bits");
  chk_reserved_zero: assert property (
    src2_q[7:4] == 4'h0)
    else $error("reserved source bits set");
  chk_irq_follows: assert property (
    (|(src2_q & en2_q)) |=> ata_irq && ata_irq_vector == 8'h48)
    else $error("enabled source gave no interrupt");
  chk_pend_flag: assert property (
    $rose(|(src2_q & en2_q)) |=> second_reg_pending_flag)
    else $error("pending flag missed");
  chk_ovrun_clear: assert property (
    transfer_start_bit && !ev_ov |=> !ovrun_q)
    else $error("start did not clear overrun");
  chk_ovrun_mis: assert property (
    host_overrun |=> ovrun_q && byte_count_mismatch_irq)
    else $error("overrun without mismatch");
  chk_udma_intrq: assert property (
    ov_q != OV_IDLE && intrq_s && !host_overrun && !ev_pio
    && !ovrun_q |=> !ovrun_q)
    else $error("overrun set despite intrq");
  chk_pin_mirror: assert property (
    mcu_rd && hit(mcu_addr, ADDR_STATUS)
    |=> mcu_rdata[3:1] == $past(pins_s, 1))
    else $error("status pins not mirrored");

  // second source events, clears and reserved bits
  chk_dseq_sets: assert property (
    ev_dseq |=> src2_q[SRC2_DSEQ])
    else $error("data sequence error not recorded");
  chk_seq_sets: assert property (
    ev_seq |=> src2_q[SRC2_SEQ])
    else $error("packet sequence error not recorded");
  chk_seq_window: assert property (
    packet_bytes_sent && !a0_wr |=> !seq_win_q)
    else $error("packet window stayed open");
  chk_w1c_clears: assert property (
    wr_src2 && ev2 == 8'h00 |=> (src2_q & $past(mcu_wdata)) == 8'h00)
    else $error("write one did not clear source");
  chk_rsv_read: assert property (
    mcu_rd && hit(mcu_addr, ADDR_SRC2) |=> mcu_rdata[7:4] == 4'h0)
    else $error("reserved source bits read nonzero");

  // command start
  chk_go_follows: assert property (
    transfer_start_bit && !drive_busy |=> auto_cmd_go)
    else $error("idle drive start gave no command");
  chk_go_needs_start: assert property (
    !transfer_start_bit |=> !auto_cmd_go)
    else $error("command launched without start");
  chk_bsy_needs_start: assert property (
    !ev_bsy && !src2_q[SRC2_BSY] |=> !src2_q[SRC2_BSY])
    else $error("busy source set without busy start");

  // overrun flag and udma pause
  chk_pio_overrun: assert property (
    ev_pio |=> ovrun_q && byte_count_mismatch_irq)
    else $error("pio overrun not flagged");
  chk_udma_sets: assert property (
    ov_q == OV_WATCH && dmarq_s && !intrq_s |=> ovrun_q)
    else $error("dmarq return did not flag overrun");
  chk_ovrun_w1c: assert property (
    wr_stat && mcu_wdata[STAT_OVRUN] && !ev_ov |=> !ovrun_q)
    else $error("write one did not clear overrun");
  chk_pause_level: assert property (
    udma_overrun && ov_q == OV_IDLE |=> udma_pause)
    else $error("udma overrun did not pause");

  // mask writes, interrupt level and status reads
  chk_mask_write: assert property (
    wr_en2 |=> en2_q == $past(mcu_wdata))
    else $error("mask write lost");
  chk_irq_idle: assert property (
    !(|act2) && !(|(act1 & keep1))
    |=> !ata_irq && ata_irq_vector == NO_VECTOR)
    else $error("interrupt with no enabled source");
  chk_vector_match: assert property (
    ata_irq |-> ata_irq_vector == ATA_VECTOR)
    else $error("interrupt vector wrong");
  chk_pend_low: assert property (
    !(|act2) |=> !second_reg_pending_flag)
    else $error("pending flag without second source");
  chk_status_ro: assert property (
    mcu_rd && hit(mcu_addr, ADDR_STATUS) |=> mcu_rdata[7:4] == 4'h0)
    else $error("status upper bits read nonzero");
  chk_dmack_mirror: assert property (
    mcu_rd && hit(mcu_addr, ADDR_STATUS)
    |=> mcu_rdata[STAT_DMACK] == $past(dmack_n_s))
    else $error("dmack pin not mirrored");
endmodule
`default_nettype wire

/* sim/drive_pins_model.sv */
// Purpose: drive-side pin model for the irq/status bench
// Assumes: bench asks for levels, model shows them after an edge
// Notes:   real drive pins are asynchronous to the bridge clock
`default_nettype none
module drive_pins_model (
  // clock
  input  wire logic clk,
  // levels asked for by the bench
  input  wire logic want_rq,
  input  wire logic want_ack,
  input  wire logic want_int,
  // drive pins
  output var  logic pin_dmarq,
  output var  logic pin_dmack_n,
  output var  logic pin_intrq
);
  timeunit 1ns;
  timeprecision 1ps;
  // skewed off the edge so the bridge sync sees a true async change
  always @(posedge clk) begin
    pin_dmarq   <= #3 want_rq;
    pin_dmack_n <= #3 ~want_ack;
    pin_intrq   <= #3 want_int;
  end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: self-checking bench for the irq/status block
// Assumes: inputs move on falling edges, read data one edge later
// Notes:   register access first, then event rows, irq, pin and overrun cases
`default_nettype none
module tb_top
  import ata_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;   // 50 MHz
  logic        rst_n = 1'b0; // held for 6 cycles
  logic [15:0] addr = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  src1 = 8'h00;
  logic [7:0]  en1 = 8'h00;
  logic [14:0] ev = 15'h0000; // start..udma event/mode inputs
  logic [7:0]  code = 8'h00;
  logic        rq = 1'b0;
  logic        ack = 1'b0;
  logic        intr = 1'b0;
  logic        seen_bcm = 1'b0; // pulses caught per row
  logic        seen_go = 1'b0;
  logic        clr = 1'b0;
  logic        pend, irq, bcm, go, pause, dmarq, dmack_n, intrq;
  logic [7:0]  rdata, vec, v;
  int          bad_count = 0;
  int          tests_run = 0;
  // {events, command code, expected source2, expected overrun}
  logic [31:0] rows [15] = '{
    {15'h1C00, 8'h00, 8'h01, 1'b0}, {15'h1800, 8'h00, 8'h00, 1'b0},
    {15'h0230, 8'h00, 8'h02, 1'b0}, {15'h0030, 8'h00, 8'h00, 1'b0},
    {15'h6000, 8'h00, 8'h08, 1'b0}, {15'h4000, 8'h00, 8'h00, 1'b0},
    {15'h0008, 8'h00, 8'h00, 1'b1}, {15'h0406, 8'h00, 8'h00, 1'b1},
    {15'h0006, 8'h00, 8'h00, 1'b0}, {15'h0380, 8'hA1, 8'h00, 1'b0},
    {15'h0320, 8'h00, 8'h00, 1'b0}, {15'h0380, 8'hA0, 8'h00, 1'b0},
    {15'h0320, 8'h00, 8'h04, 1'b0}, {15'h0340, 8'h00, 8'h00, 1'b0},
    {15'h0320, 8'h00, 8'h00, 1'b0}};
  always #10 clk = ~clk;
  // one-cycle outputs are caught here so no edge race can hide them
  always @(posedge clk) begin
    seen_bcm <= ~clr & (seen_bcm | bcm);
    seen_go  <= ~clr & (seen_go | go);
  end
  ata_bridge_irq_status i_dut (.clk(clk), .rst_n(rst_n),
    .mcu_addr(addr), .mcu_wr(wr), .mcu_rd(rd), .mcu_wdata(wdata),
    .mcu_rdata(rdata), .irq_source_first_reg(src1),
    .irq_enable_first_reg(en1), .second_reg_pending_flag(pend),
    .ata_irq(irq), .ata_irq_vector(vec), .transfer_start_bit(ev[14]),
    .drive_busy(ev[13]), .cmd_issue(ev[12]), .nondata_cmd_cfg(ev[11]),
    .drive_drq(ev[10]), .packet_mode(ev[9]), .full_auto_seq(ev[8]),
    .cmd_code_wr(ev[7]), .cmd_code(code), .packet_bytes_sent(ev[6]),
    .seq_err(ev[5]), .data_phase(ev[4]), .host_overrun(ev[3]),
    .pio_auto(ev[2]), .status_read_done(ev[1]), .udma_overrun(ev[0]),
    .auto_cmd_go(go), .byte_count_mismatch_irq(bcm), .udma_pause(pause),
    .pin_dmarq(dmarq), .pin_dmack_n(dmack_n), .pin_intrq(intrq));
  drive_pins_model i_drive (.clk(clk), .want_rq(rq), .want_ack(ack),
    .want_int(intr), .pin_dmarq(dmarq), .pin_dmack_n(dmack_n),
    .pin_intrq(intrq));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one register cycle, strobe held for exactly one edge
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wr = w;
    rd = ~w;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    v = rdata;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(v & m, e);
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input logic [14:0] e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = 15'h0000;
  endtask
  task automatic results();
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    gap(6);
    rst_n = 1'b1;
    rdc(ADDR_SRC2, 8'hFF, SRC2_RESET);
    acc(1'b1, ADDR_EN2, 8'hA5);
    rdc(ADDR_EN2, 8'hFF, 8'hA5);
    rdc(16'hF0EB, 8'hFF, 8'h00);
    acc(1'b1, ADDR_EN2, 8'h00);
    foreach (rows[i]) begin
      clr = 1'b1;
      code = rows[i][16:9];
      gap(1);
      clr = 1'b0;
      pulse(rows[i][31:17]);
      gap(3);
      chk({7'h00, seen_go}, {7'h00, rows[i][31] & ~rows[i][30]});
      chk({7'h00, seen_bcm}, {7'h00, rows[i][0]});
      rdc(ADDR_SRC2, 8'hFF, rows[i][8:1]);
      rdc(ADDR_STATUS, 8'h01, {7'h00, rows[i][0]});
      acc(1'b1, ADDR_SRC2, 8'hFF);
      acc(1'b1, ADDR_STATUS, 8'h01);
    end
    // enabled source raises irq, zero write keeps it, mask drops it
    acc(1'b1, ADDR_EN2, 8'h0F);
    pulse(15'h1C00);
    gap(3);
    chk({irq, pend, 6'h00}, 8'hC0);
    chk(vec, ATA_VECTOR);
    acc(1'b1, ADDR_SRC2, 8'h00);
    rdc(ADDR_SRC2, 8'hFF, 8'h01);
    acc(1'b1, ADDR_EN2, 8'h00);
    gap(3);
    chk({irq, pend, 6'h00}, 8'h00);
    chk(vec, NO_VECTOR);
    acc(1'b1, ADDR_SRC2, 8'h01);
    src1 = 8'h01;
    en1 = 8'h01;
    gap(3);
    chk({7'h00, irq}, 8'h00);
    src1 = 8'h04;
    en1 = 8'h04;
    gap(3);
    chk({7'h00, irq}, 8'h01);
    en1 = 8'h00;
    // pin mirror survives a write of all ones
    rq = 1'b1;
    ack = 1'b1;
    intr = 1'b1;
    gap(5);
    acc(1'b1, ADDR_STATUS, 8'hFF);
    rdc(ADDR_STATUS, 8'h0F, 8'h0A);
    rq = 1'b0;
    ack = 1'b0;
    intr = 1'b0;
    gap(5);
    rdc(ADDR_STATUS, 8'h0F, 8'h04);
    // udma overrun: dmarq back alone sets, intrq aborts
    pulse(15'h0001);
    gap(4);
    chk({7'h00, pause}, 8'h01);
    rq = 1'b1;
    gap(8);
    rdc(ADDR_STATUS, 8'h01, 8'h01);
    chk({7'h00, pause}, 8'h00);
    rq = 1'b0;
    acc(1'b1, ADDR_STATUS, 8'h01);
    gap(4);
    pulse(15'h0001);
    gap(4);
    intr = 1'b1;
    rq = 1'b1;
    gap(8);
    rdc(ADDR_STATUS, 8'h01, 8'h00);
    chk({7'h00, pause}, 8'h00);
    // zero write keeps overrun, start bit clears it
    pulse(15'h0008);
    acc(1'b1, ADDR_STATUS, 8'h00);
    rdc(ADDR_STATUS, 8'h01, 8'h01);
    pulse(15'h4000);
    gap(2);
    rdc(ADDR_STATUS, 8'h01, 8'h00);
    // mid-run reset returns every register and output to zero
    acc(1'b1, ADDR_EN2, 8'h0F);
    pulse(15'h1C08);
    gap(2);
    chk({7'h00, irq}, 8'h01);
    rst_n = 1'b0;
    gap(3);
    rst_n = 1'b1;
    chk({irq, pend, go, bcm, pause, 3'h0}, 8'h00);
    chk(vec, NO_VECTOR);
    chk(rdata, 8'h00);
    rdc(ADDR_SRC2, 8'hFF, SRC2_RESET);
    rdc(ADDR_EN2, 8'hFF, EN2_RESET);
    rdc(ADDR_STATUS, 8'h01, {7'h00, OVRUN_RESET});
    results();
  end
  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
